// ### design/tce_pkg.sv
// Package: constants and carriers of the terminal controller error block
package tce_pkg;
	// Register offsets
	localparam logic [7:0] OFS_HOST_STATUS = 8'h00;
	localparam logic [7:0] OFS_REASON = 8'h01;
	localparam logic [7:0] OFS_IRQ_STATUS = 8'h02;
	localparam logic [7:0] OFS_IRQ_CLEAR = 8'h03;
	localparam logic [7:0] OFS_IRQ_ENABLE = 8'h04;
	localparam logic [7:0] OFS_CONTROL = 8'h05;
	// Status byte fields, bit 0 is the most significant bit
	localparam int ST_PROG0 = 7;
	localparam int ST_PROG1 = 6;
	localparam int ST_PROG2 = 5;
	localparam int ST_BUS_PAR = 4;
	localparam int ST_OP_CHECK = 3;
	localparam int ST_STOR_PAR = 2;
	localparam int ST_DONT_CARE = 1;
	localparam int ST_LONG_TO = 0;
	// Failure reason codes
	localparam logic [7:0] RC_SEE_STATUS = 8'h00;
	localparam logic [7:0] RC_SERIAL_TO = 8'h01;
	localparam logic [7:0] RC_CYCLE_STEAL_TO = 8'h02;
	localparam logic [7:0] RC_NO_INTERRUPTS = 8'h05;
	// Interrupt status fields
	localparam int IRQ_BITS = 5;
	localparam int IRQ_PROG = 0;
	localparam int IRQ_BUS_PAR = 1;
	localparam int IRQ_OP_CHECK = 2;
	localparam int IRQ_STOR_PAR = 3;
	localparam int IRQ_LONG_TO = 4;
	// Control register fields
	localparam int CTL_CLEAR_PROG = 0;
	localparam int CTL_WDOG_KICK = 1;
	// Reset values
	localparam logic [7:0] RST_STATUS = 8'h00;
	localparam logic [7:0] RST_REASON = 8'h00;
	localparam logic [IRQ_BITS-1:0] RST_IRQ = 5'h00;
	// Timing
	localparam int CLK_HZ = 100_000_000;
	localparam int WDOG_TIME_S = 7;
	localparam int WDOG_CYCLES = WDOG_TIME_S * CLK_HZ;
	localparam int IDLE_TIME_MS = 30;
	localparam int IDLE_CYCLES = IDLE_TIME_MS * (CLK_HZ / 1000);
	// One beat on a host data bus or the storage bus
	typedef struct packed {
		logic valid;
		logic [7:0] data;
		logic parity;
	} tce_beat_t;
	// One entry of the controller error history
	typedef struct packed {
		logic [7:0] status;
		logic [7:0] reason;
	} tce_log_entry_t;
endpackage : tce_pkg

// ### design/tce_error_status.sv
// Error detection and status reporting of the terminal controller
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Parity checked on both host buses; error sets status bit 3.
// - Host bus parity error halts the controller and flags the host.
// - Detected hardware fault sets status bit 4 plus a reason code.
// - Parity checked on storage read data; error sets status bit 5.
// - Watchdog not restarted within 7 seconds sets status bit 7.
// - Bits 0 to 2 report programming errors, shown but never logged.
// - Reason 01 reports a serial frame transmit timeout.
// - Reason 02 reports a cycle steal timeout.
// - Reason 05 reports 30 ms without any internal interrupt.
// - Reason 00 points at bits 3, 5, 7; codes 03, 04 never made.
// - Only whole-controller failures log both status bytes.
module tce_error_status #(
	parameter int WDOG_CYCLES = tce_pkg::WDOG_CYCLES,
	parameter int IDLE_CYCLES = tce_pkg::IDLE_CYCLES,
	parameter bit ODD_PARITY = 1'b1
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic nrst,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// Host buses and local storage
	input wire tce_pkg::tce_beat_t outbound_host_bus,
	input wire tce_pkg::tce_beat_t inbound_host_bus,
	input wire tce_pkg::tce_beat_t storage_bus,
	// Firmware events
	input wire logic [2:0] prog_err,
	input wire logic fw_interrupt,
	input wire logic serial_tx_timeout,
	input wire logic cycle_steal_timeout,
	// Controller state towards the host and the error history
	output logic halted,
	output logic host_fail,
	output logic log_valid,
	output tce_pkg::tce_log_entry_t log_entry,
	output logic irq
);

	logic [7:0] status;
	logic [7:0] reason;
	logic [7:0] next_status;
	logic [7:0] next_reason;
	logic [tce_pkg::IRQ_BITS-1:0] irq_status;
	logic [tce_pkg::IRQ_BITS-1:0] irq_enable;
	logic [31:0] wdog_cnt;
	logic [31:0] idle_cnt;
	logic bus_par_err;
	logic stor_par_err;
	logic wdog_expire;
	logic idle_expire;
	logic op_fault;
	logic fatal_event;
	logic wr_ctl;
	logic wdog_kick;
	logic [tce_pkg::IRQ_BITS-1:0] irq_event;

	// Parity of data plus parity bit must equal the chosen sense
	function automatic logic beat_bad(input tce_pkg::tce_beat_t b);
		beat_bad = b.valid && ((^{b.data, b.parity}) != ODD_PARITY);
	endfunction : beat_bad

	assign wr_ctl = reg_wr && (reg_addr == tce_pkg::OFS_CONTROL);
	assign wdog_kick = wr_ctl && reg_wdata[tce_pkg::CTL_WDOG_KICK];

	// both bus parity
	// Once halted the buses are no longer watched, so a stuck bus does
	// not keep refiring the error log.
	assign bus_par_err = !halted &&
		(beat_bad(outbound_host_bus) || beat_bad(inbound_host_bus));
	assign stor_par_err = !halted && beat_bad(storage_bus);

	assign wdog_expire = !status[tce_pkg::ST_LONG_TO] &&
		(wdog_cnt == 32'(WDOG_CYCLES - 1)) && !wdog_kick;
	assign idle_expire = !halted && !fw_interrupt &&
		(idle_cnt == 32'(IDLE_CYCLES - 1));

	assign op_fault = !halted &&
		(serial_tx_timeout || cycle_steal_timeout || idle_expire);

	// complete failures only
	// Programming errors are deliberately left out of this term.
	assign fatal_event = bus_par_err || stor_par_err || wdog_expire ||
		op_fault;

	always_comb begin
		next_status = status;
		next_reason = reason;
		if (wr_ctl && reg_wdata[tce_pkg::CTL_CLEAR_PROG]) begin
			next_status[tce_pkg::ST_PROG0] = 1'b0;
			next_status[tce_pkg::ST_PROG1] = 1'b0;
			next_status[tce_pkg::ST_PROG2] = 1'b0;
		end
		// Set wins over the software clear in the same cycle
		if (prog_err[0]) begin
			next_status[tce_pkg::ST_PROG0] = 1'b1;
		end
		if (prog_err[1]) begin
			next_status[tce_pkg::ST_PROG1] = 1'b1;
		end
		if (prog_err[2]) begin
			next_status[tce_pkg::ST_PROG2] = 1'b1;
		end
		if (op_fault) begin
			next_status[tce_pkg::ST_OP_CHECK] = 1'b1;
			if (serial_tx_timeout) begin
				next_reason = tce_pkg::RC_SERIAL_TO;
			end else if (cycle_steal_timeout) begin
				next_reason = tce_pkg::RC_CYCLE_STEAL_TO;
			end else begin
				next_reason = tce_pkg::RC_NO_INTERRUPTS;
			end
		end
		if (bus_par_err) begin
			next_status[tce_pkg::ST_BUS_PAR] = 1'b1;
		end
		if (stor_par_err) begin
			next_status[tce_pkg::ST_STOR_PAR] = 1'b1;
		end
		if (wdog_expire) begin
			next_status[tce_pkg::ST_LONG_TO] = 1'b1;
		end
		if (bus_par_err || stor_par_err || wdog_expire) begin
			next_reason = tce_pkg::RC_SEE_STATUS;
		end
		next_status[tce_pkg::ST_DONT_CARE] = 1'b0;
	end

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			status <= tce_pkg::RST_STATUS;
			reason <= tce_pkg::RST_REASON;
		end else begin
			status <= next_status;
			reason <= next_reason;
		end
	end

	// Watchdog: only a control register write restarts it
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			wdog_cnt <= 32'h0000_0000;
		end else if (wdog_kick) begin
			wdog_cnt <= 32'h0000_0000;
		end else if (wdog_cnt != 32'(WDOG_CYCLES - 1)) begin
			wdog_cnt <= wdog_cnt + 32'h0000_0001;
		end
	end

	// Interrupt activity monitor rearms after each silence report
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			idle_cnt <= 32'h0000_0000;
		end else if (fw_interrupt || idle_expire || halted) begin
			idle_cnt <= 32'h0000_0000;
		end else begin
			idle_cnt <= idle_cnt + 32'h0000_0001;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			halted <= 1'b0;
			host_fail <= 1'b0;
		end else if (bus_par_err) begin
			halted <= 1'b1;
			host_fail <= 1'b1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			log_valid <= 1'b0;
			log_entry <= '0;
		end else begin
			log_valid <= fatal_event;
			if (fatal_event) begin
				log_entry.status <= next_status;
				log_entry.reason <= next_reason;
			end
		end
	end

	// Interrupt status, clear and enable
	assign irq_event[tce_pkg::IRQ_PROG] = |prog_err;
	assign irq_event[tce_pkg::IRQ_BUS_PAR] = bus_par_err;
	assign irq_event[tce_pkg::IRQ_OP_CHECK] = op_fault;
	assign irq_event[tce_pkg::IRQ_STOR_PAR] = stor_par_err;
	assign irq_event[tce_pkg::IRQ_LONG_TO] = wdog_expire;

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			irq_status <= tce_pkg::RST_IRQ;
		end else if (reg_wr && (reg_addr == tce_pkg::OFS_IRQ_CLEAR)) begin
			irq_status <= (irq_status &
				~reg_wdata[tce_pkg::IRQ_BITS-1:0]) | irq_event;
		end else begin
			irq_status <= irq_status | irq_event;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			irq_enable <= tce_pkg::RST_IRQ;
		end else if (reg_wr && (reg_addr == tce_pkg::OFS_IRQ_ENABLE)) begin
			irq_enable <= reg_wdata[tce_pkg::IRQ_BITS-1:0];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			irq <= 1'b0;
		end else begin
			irq <= |(irq_status & irq_enable);
		end
	end

	// Register read; unmapped and write-only offsets read as zero
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			unique case (reg_addr)
				tce_pkg::OFS_HOST_STATUS: reg_rdata <= status;
				tce_pkg::OFS_REASON: reg_rdata <= reason;
				tce_pkg::OFS_IRQ_STATUS:
					reg_rdata <= {3'h0, irq_status};
				tce_pkg::OFS_IRQ_ENABLE:
					reg_rdata <= {3'h0, irq_enable};
				default: reg_rdata <= 8'h00;
			endcase
		end else begin
			reg_rdata <= 8'h00;
		end
	end

	bus_parity_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		bus_par_err |=> status[tce_pkg::ST_BUS_PAR])
		else $error("bus parity error did not set status bit 3");

	halt_on_parity_a: assert property (@(posedge sys_clk)
		disable iff (!nrst)
		bus_par_err |=> (halted && host_fail) [*3])
		else $error("controller did not halt on bus parity error");

	op_check_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		$rose(status[tce_pkg::ST_OP_CHECK]) |->
		$past(op_fault))
		else $error("operation check set without a fault");

	stor_parity_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		(storage_bus.valid && !halted &&
		((^{storage_bus.data, storage_bus.parity}) != ODD_PARITY))
		|=> status[tce_pkg::ST_STOR_PAR])
		else $error("storage parity error did not set status bit 5");

	wdog_limit_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		$rose(status[tce_pkg::ST_LONG_TO]) |->
		($past(wdog_cnt) == 32'(WDOG_CYCLES - 1)))
		else $error("long timeout set at the wrong count");

	prog_not_logged_a: assert property (@(posedge sys_clk)
		disable iff (!nrst)
		(|prog_err && !fatal_event) |=> !log_valid)
		else $error("programming error produced a log entry");

	serial_code_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		(op_fault && serial_tx_timeout && !bus_par_err && !stor_par_err
		&& !wdog_expire) |=> (reason == tce_pkg::RC_SERIAL_TO))
		else $error("serial timeout did not report code 01");

	cs_code_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		(op_fault && cycle_steal_timeout && !serial_tx_timeout &&
		!bus_par_err && !stor_par_err && !wdog_expire)
		|=> (reason == tce_pkg::RC_CYCLE_STEAL_TO))
		else $error("cycle steal timeout did not report code 02");

	idle_code_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		idle_expire |-> ($past(idle_cnt) == 32'(IDLE_CYCLES - 2)) ##1
		(status[tce_pkg::ST_OP_CHECK] &&
		(reason != tce_pkg::RC_SEE_STATUS || $past(bus_par_err) ||
		$past(stor_par_err) || $past(wdog_expire))))
		else $error("interrupt silence not reported");

	no_spare_code_a: assert property (@(posedge sys_clk)
		disable iff (!nrst)
		(reason != 8'h03) && (reason != 8'h04))
		else $error("unassigned reason code produced");

	log_entry_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		fatal_event |=> (log_valid && log_entry.status == status &&
		log_entry.reason == reason))
		else $error("log entry does not match status bytes");

	dont_care_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		!status[tce_pkg::ST_DONT_CARE])
		else $error("status bit 6 is not zero");

	halt_sticky_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		halted |=> (halted && host_fail))
		else $error("controller left the halted state without reset");

	log_cause_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		log_valid |-> $past(fatal_event))
		else $error("log entry without a controller failure");

endmodule : tce_error_status

`default_nettype wire

// ### tb/tce_host_model.sv
// Host side model that drives beats on the two host data buses
`timescale 1ns/1ps
`default_nettype none
module tce_host_model (
	// Clock
	input wire logic sys_clk,
	// Requests from the bench
	input wire logic send_out,
	input wire logic send_in,
	input wire logic bad_par,
	input wire logic [7:0] data,
	// Host buses
	output var tce_pkg::tce_beat_t outbound_host_bus,
	output var tce_pkg::tce_beat_t inbound_host_bus
);
	initial begin
		outbound_host_bus = '0;
		inbound_host_bus = '0;
	end
	// Released buses drop valid and invert their data each cycle, so a stale beat never looks valid
	always @(posedge sys_clk) begin
		outbound_host_bus.valid <= send_out;
		inbound_host_bus.valid <= send_in;
		outbound_host_bus.data <= send_out ? data : ~outbound_host_bus.data;
		inbound_host_bus.data <= send_in ? data : ~inbound_host_bus.data;
		outbound_host_bus.parity <= ~^data ^ bad_par;
		inbound_host_bus.parity <= ~^data ^ bad_par;
	end
endmodule : tce_host_model
`default_nettype wire

// ### tb/tb.sv
// Self-checking bench of the terminal controller error block
`timescale 1ns/1ps
`default_nettype none
module tb;
	typedef struct {logic [2:0] prog; logic [7:0] st;} tce_row_t;
	tce_row_t rows [4] = '{'{3'h1, 8'h80}, '{3'h2, 8'h40}, '{3'h4, 8'h20},
		'{3'h7, 8'hE0}};
	logic sys_clk = 1'b0;
	logic nrst = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_rdata;
	tce_pkg::tce_beat_t ob_bus;
	tce_pkg::tce_beat_t ib_bus;
	tce_pkg::tce_beat_t storage_bus = '0;
	logic [2:0] prog_err = 3'h0;
	logic fw_interrupt = 1'b1;
	logic serial_to = 1'b0;
	logic cs_to = 1'b0;
	logic halted, host_fail, log_valid, irq;
	tce_pkg::tce_log_entry_t log_entry;
	logic send_out = 1'b0;
	logic send_in = 1'b0;
	logic bad_par = 1'b0;
	logic [7:0] hdata = 8'h3C;
	int err_total = 0;
	int n_checks = 0;
	int n;

	always #5 sys_clk = ~sys_clk;

	tce_host_model u_tce_host_model (.sys_clk(sys_clk), .send_out(send_out),
		.send_in(send_in), .bad_par(bad_par), .data(hdata),
		.outbound_host_bus(ob_bus), .inbound_host_bus(ib_bus));

	tce_error_status #(.WDOG_CYCLES(50), .IDLE_CYCLES(20)) u_tce_error_status (
		.sys_clk(sys_clk), .nrst(nrst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .outbound_host_bus(ob_bus),
		.inbound_host_bus(ib_bus), .storage_bus(storage_bus),
		.prog_err(prog_err), .fw_interrupt(fw_interrupt),
		.serial_tx_timeout(serial_to), .cycle_steal_timeout(cs_to),
		.halted(halted), .host_fail(host_fail), .log_valid(log_valid),
		.log_entry(log_entry), .irq(irq));

	task end_of_test;
		if (err_total == 0 && n_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : end_of_test

	task chk(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_total++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask : wr

	task rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge sys_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, e);
	endtask : rd

	task ev(input logic [1:0] k);
		@(posedge sys_clk);
		{cs_to, serial_to} <= k;
		@(posedge sys_clk);
		{cs_to, serial_to} <= 2'b00;
		#1;
	endtask : ev

	// A wait that runs out is counted and closes the run
	task wait_log(input int lim);
		n = 0;
		do begin
			@(posedge sys_clk);
			#1 n++;
		end while (log_valid !== 1'b1 && n < lim);
		if (n >= lim) begin
			err_total++;
			end_of_test();
		end
	endtask : wait_log

	initial begin
		repeat (12) @(posedge sys_clk);
		nrst <= 1'b1;
		rd(tce_pkg::OFS_HOST_STATUS, 8'h00);
		foreach (rows[i]) begin
			@(posedge sys_clk);
			prog_err <= rows[i].prog;
			@(posedge sys_clk);
			prog_err <= 3'h0;
			#1 chk(log_valid, 1'b0);
			rd(tce_pkg::OFS_HOST_STATUS, rows[i].st);
			wr(tce_pkg::OFS_CONTROL, 8'h03);
			rd(tce_pkg::OFS_HOST_STATUS, 8'h00);
		end
		rd(8'h07, 8'h00);
		wr(tce_pkg::OFS_HOST_STATUS, 8'hFF);
		rd(tce_pkg::OFS_HOST_STATUS, 8'h00);
		wr(tce_pkg::OFS_IRQ_CLEAR, 8'h1F);
		rd(tce_pkg::OFS_IRQ_STATUS, 8'h00);
		wr(tce_pkg::OFS_IRQ_ENABLE, 8'h1F);
		rd(tce_pkg::OFS_IRQ_ENABLE, 8'h1F);
		chk(irq, 1'b0);
		ev(2'b01);
		chk(log_valid, 1'b1);
		chk(log_entry, 16'h0801);
		@(posedge sys_clk);
		#1 chk(irq, 1'b1);
		wr(tce_pkg::OFS_IRQ_CLEAR, 8'h1F);
		@(posedge sys_clk);
		#1 chk(irq, 1'b0);
		ev(2'b10);
		chk(log_entry, 16'h0802);
		rd(tce_pkg::OFS_REASON, 8'h02);
		// Silence on the firmware interrupt must be noticed after 20 cycles
		wr(tce_pkg::OFS_CONTROL, 8'h02);
		fw_interrupt <= 1'b0;
		wait_log(40);
		fw_interrupt <= 1'b1;
		chk(n >= 18 && n <= 22, 1'b1);
		chk(log_entry, 16'h0805);
		@(posedge sys_clk);
		storage_bus <= '{1'b1, 8'h5A, ^8'h5A};
		@(posedge sys_clk);
		storage_bus <= '{1'b0, 8'hA5, 1'b1};
		#1 chk(log_entry, 16'h0C00);
		wr(tce_pkg::OFS_CONTROL, 8'h02);
		wait_log(80);
		chk(n >= 47 && n <= 53, 1'b1);
		chk(log_entry, 16'h0D00);
		wr(tce_pkg::OFS_CONTROL, 8'h02);
		@(posedge sys_clk);
		send_out <= 1'b1;
		bad_par <= 1'b1;
		@(posedge sys_clk);
		send_out <= 1'b0;
		bad_par <= 1'b0;
		wait_log(5);
		chk({halted, host_fail}, 2'b11);
		chk(log_entry, 16'h1D00);
		ev(2'b01);
		rd(tce_pkg::OFS_REASON, 8'h00);
		@(posedge sys_clk);
		nrst <= 1'b0;
		repeat (2) @(posedge sys_clk);
		nrst <= 1'b1;
		@(posedge sys_clk);
		#1 chk({halted, host_fail}, 2'b00);
		rd(tce_pkg::OFS_HOST_STATUS, 8'h00);
		@(posedge sys_clk);
		send_in <= 1'b1;
		@(posedge sys_clk);
		send_in <= 1'b0;
		@(posedge sys_clk);
		#1 chk(halted, 1'b0);
		@(posedge sys_clk);
		send_in <= 1'b1;
		bad_par <= 1'b1;
		@(posedge sys_clk);
		send_in <= 1'b0;
		wait_log(5);
		chk(log_entry, 16'h1000);
		end_of_test();
	end
endmodule : tb
`default_nettype wire
